// *** jtag_debug_access_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "jdap_consts.svh"
module jtag_debug_access_port #(
	parameter int PAD_N = 16,
	parameter logic [31:0] IDCODE_VALUE = 32'h1234_5001 // arbitrary value
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tap_compliance_enable,
	output logic tdo_out,
	output logic tdo_oe,
	input wire logic [PAD_N-1:0] pad_in,
	input wire logic [PAD_N-1:0] core_pad_out,
	input wire logic [PAD_N-1:0] core_pad_oe,
	output logic [PAD_N-1:0] pad_out,
	output logic [PAD_N-1:0] pad_oe,
	input wire logic [63:0] boot_password,
	output logic censor_lifted,
	input wire logic br_valid,
	input wire logic [1:0] br_type,
	input wire logic [31:0] br_addr,
	input wire logic wp_hit,
	input wire logic event_in_pin,
	input wire logic por_status,
	input wire logic [7:0] gpio_dout,
	output logic [11:0] message_data_out,
	output logic [1:0] message_start_end_out,
	output logic message_clock_out,
	output logic event_out_pin,
	input wire logic cpu_wr_valid,
	input wire logic [31:0] cpu_wr_addr,
	input wire logic [31:0] cpu_wr_data,
	input wire logic [1:0] cpu_wr_size,
	output logic cpu_halt_req,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic tp_brk_en,
	output logic [31:0] tp_brk_addr,
	output logic tp_step
);
	localparam int SW = 6 + PAD_N;
	logic [SW-1:0] s1_reg, s2_reg;
	logic tck_d_reg, tck_s, tms_s, tdi_s, tce_s, event_in_pin_s, event_in_pin_d_reg, por_s;
	logic [PAD_N-1:0] pad_s;
	logic tck_rise, tck_fall;
	jdap_pkg::tap_state_t state_reg;
	logic [`IR_W-1:0] ir_reg, ir_sh_reg;
	logic [`DR_SH_W-1:0] dr_sh_reg, dr_val;
	logic [6:0] dr_len;
	logic [PAD_N-1:0] bsr_upd_reg;
	logic [5:0] cfg_reg;
	logic [31:0] mem_rdata_reg;
	logic armed_reg;
	logic [3:0] dvb_en_reg, dvb_ne_reg, dvb_hit;
	logic [1:0] dvb_size_reg [4];
	logic [31:0] dvb_addr_reg [4];
	logic [31:0] dvb_val_reg [4];
	logic upd_dr, test_pins;

	// two flops on every pin-side input; only stage two is read
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= {tck, tms, tdi, tap_compliance_enable, event_in_pin, por_status, pad_in};
			s2_reg <= s1_reg;
		end
	end
	assign {tck_s, tms_s, tdi_s, tce_s, event_in_pin_s, por_s, pad_s} = s2_reg;

	// edges of the slow test clock found with the system clock
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tck_d_reg <= 1'b0;
			event_in_pin_d_reg <= 1'b0;
		end else begin
			tck_d_reg <= tck_s;
			event_in_pin_d_reg <= event_in_pin_s;
		end
	end
	assign tck_rise = tck_s & ~tck_d_reg;
	assign tck_fall = ~tck_s & tck_d_reg;
	assign upd_dr = tck_fall && state_reg == jdap_pkg::UPD_DR;

	function automatic jdap_pkg::tap_state_t tap_next(input jdap_pkg::tap_state_t s,
		input logic m);
		unique case (s)
			jdap_pkg::TLR: tap_next = m ? jdap_pkg::TLR : jdap_pkg::RTI;
			jdap_pkg::RTI: tap_next = m ? jdap_pkg::SEL_DR : jdap_pkg::RTI;
			jdap_pkg::SEL_DR: tap_next = m ? jdap_pkg::SEL_IR : jdap_pkg::CAP_DR;
			jdap_pkg::CAP_DR: tap_next = m ? jdap_pkg::EX1_DR : jdap_pkg::SH_DR;
			jdap_pkg::SH_DR: tap_next = m ? jdap_pkg::EX1_DR : jdap_pkg::SH_DR;
			jdap_pkg::EX1_DR: tap_next = m ? jdap_pkg::UPD_DR : jdap_pkg::PAUSE_DR;
			jdap_pkg::PAUSE_DR: tap_next = m ? jdap_pkg::EX2_DR : jdap_pkg::PAUSE_DR;
			jdap_pkg::EX2_DR: tap_next = m ? jdap_pkg::UPD_DR : jdap_pkg::SH_DR;
			jdap_pkg::UPD_DR: tap_next = m ? jdap_pkg::SEL_DR : jdap_pkg::RTI;
			jdap_pkg::SEL_IR: tap_next = m ? jdap_pkg::TLR : jdap_pkg::CAP_IR;
			jdap_pkg::CAP_IR: tap_next = m ? jdap_pkg::EX1_IR : jdap_pkg::SH_IR;
			jdap_pkg::SH_IR: tap_next = m ? jdap_pkg::EX1_IR : jdap_pkg::SH_IR;
			jdap_pkg::EX1_IR: tap_next = m ? jdap_pkg::UPD_IR : jdap_pkg::PAUSE_IR;
			jdap_pkg::PAUSE_IR: tap_next = m ? jdap_pkg::EX2_IR : jdap_pkg::PAUSE_IR;
			jdap_pkg::EX2_IR: tap_next = m ? jdap_pkg::UPD_IR : jdap_pkg::SH_IR;
			jdap_pkg::UPD_IR: tap_next = m ? jdap_pkg::SEL_DR : jdap_pkg::RTI;
		endcase
	endfunction

	// data register length per instruction; unknown codes fall back to bypass
	function automatic logic [6:0] len_of(input logic [`IR_W-1:0] ir);
		unique case (ir)
			`IR_IDCODE: len_of = `LEN_IDCODE;
			`IR_EXTEST, `IR_SAMPLE, `IR_SAMPLE_PRELOAD: len_of = 7'(PAD_N);
			`IR_SEL_TRACE: len_of = `LEN_TRACE;
			`IR_SEL_CORE: len_of = `LEN_CORE;
			`IR_SEL_TIMEPROC: len_of = `LEN_TIMEPROC;
			`IR_SEL_LOCK: len_of = `LEN_LOCK;
			default: len_of = `LEN_BYPASS;
		endcase
	endfunction
	assign dr_len = len_of(ir_reg);
	assign dr_val = dr_sh_reg; // bits above the selected length stay zero

	// compliance enable low holds the port in test-logic-reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= jdap_pkg::TLR;
		end else if (!tce_s) begin
			state_reg <= jdap_pkg::TLR;
		end else if (tck_rise) begin
			state_reg <= tap_next(state_reg, tms_s);
		end
	end

	// instruction path: capture and shift on rise, update on fall
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ir_reg <= `IR_IDCODE;
			ir_sh_reg <= '0;
		end else if (state_reg == jdap_pkg::TLR) begin
			ir_reg <= `IR_IDCODE;
		end else begin
			if (tck_rise && state_reg == jdap_pkg::CAP_IR)
				ir_sh_reg <= `IR_CAPTURE;
			else if (tck_rise && state_reg == jdap_pkg::SH_IR)
				ir_sh_reg <= {tdi_s, ir_sh_reg[`IR_W-1:1]};
			if (tck_fall && state_reg == jdap_pkg::UPD_IR)
				ir_reg <= ir_sh_reg;
		end
	end

	// one shared shifter; tdi enters at the top of the selected length, so the
	// one-stage bypass echoes tdi a clock later and no realignment is needed
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dr_sh_reg <= '0;
		end else if (tck_rise && state_reg == jdap_pkg::CAP_DR) begin
			dr_sh_reg <= '0;
			unique case (ir_reg)
				`IR_IDCODE: dr_sh_reg[31:0] <= IDCODE_VALUE;
				`IR_EXTEST, `IR_SAMPLE, `IR_SAMPLE_PRELOAD: dr_sh_reg[PAD_N-1:0] <= pad_s;
				`IR_SEL_TRACE: dr_sh_reg <= {2'b00, mem_addr, mem_rdata_reg, cfg_reg};
				`IR_SEL_TIMEPROC: dr_sh_reg[32:0] <= {tp_brk_en, tp_brk_addr};
				default: dr_sh_reg <= '0; // password never reads back
			endcase
		end else if (tck_rise && state_reg == jdap_pkg::SH_DR) begin
			dr_sh_reg <= dr_sh_reg >> 1;
			dr_sh_reg[dr_len - 7'd1] <= tdi_s;
		end
	end

	// data out changes on the falling test clock and floats outside shifts
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tdo_out <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo_out <= (state_reg == jdap_pkg::SH_IR) ? ir_sh_reg[0] : dr_sh_reg[0];
			tdo_oe <= state_reg == jdap_pkg::SH_IR || state_reg == jdap_pkg::SH_DR;
		end
	end

	// boundary update stage and pad muxing
	assign test_pins = ir_reg == `IR_EXTEST || ir_reg == `IR_CLAMP || ir_reg == `IR_HIGHZ;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bsr_upd_reg <= '0;
			pad_out <= '0;
			pad_oe <= '0;
		end else begin
			if (upd_dr && (ir_reg == `IR_EXTEST || ir_reg == `IR_SAMPLE_PRELOAD))
				bsr_upd_reg <= dr_val[PAD_N-1:0];
			pad_out <= test_pins ? bsr_upd_reg : core_pad_out;
			pad_oe <= ir_reg == `IR_HIGHZ ? '0 : test_pins ? '1 : core_pad_oe;
		end
	end

	// censorship stays lifted until rst_b; a mismatch leaves it alone
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			censor_lifted <= 1'b0;
		else if (upd_dr && ir_reg == `IR_SEL_LOCK && dr_val[63:0] == boot_password)
			censor_lifted <= 1'b1;
	end

	// trace tap: configuration and run-time memory access; the core is never stalled
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_reg <= `CFG_RESET;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
			mem_rdata_reg <= '0;
		end else begin
			if (mem_ack && mem_req && !mem_we)
				mem_rdata_reg <= mem_rdata;
			if (upd_dr && ir_reg == `IR_SEL_TRACE) begin
				unique case (dr_val[71:70])
					`TRC_OP_CFG: cfg_reg <= dr_val[5:0];
					`TRC_OP_READ, `TRC_OP_WRITE: begin
						mem_req <= 1'b1;
						mem_we <= dr_val[71:70] == `TRC_OP_WRITE;
						mem_addr <= dr_val[69:38];
						mem_wdata <= dr_val[37:6];
					end
					default: ;
				endcase
			end else if (mem_ack) begin
				mem_req <= 1'b0;
			end
		end
	end

	// time-processor tap: breakpoint setup and a one-cycle step
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tp_brk_en <= 1'b0;
			tp_brk_addr <= '0;
			tp_step <= 1'b0;
		end else begin
			tp_step <= upd_dr && ir_reg == `IR_SEL_TIMEPROC && dr_val[33];
			if (upd_dr && ir_reg == `IR_SEL_TIMEPROC) begin
				tp_brk_en <= dr_val[32];
				tp_brk_addr <= dr_val[31:0];
			end
		end
	end

	// core tap loads one breakpoint slot per update, chosen by its index field
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dvb_en_reg <= '0;
			dvb_ne_reg <= '0;
			for (int i = 0; i < 4; i++) begin
				dvb_size_reg[i] <= `DVB_WORD;
				dvb_addr_reg[i] <= '0;
				dvb_val_reg[i] <= '0;
			end
		end else if (upd_dr && ir_reg == `IR_SEL_CORE) begin
			dvb_en_reg[dr_val[69:68]] <= dr_val[67];
			dvb_ne_reg[dr_val[69:68]] <= dr_val[66];
			dvb_size_reg[dr_val[69:68]] <= dr_val[65:64];
			dvb_addr_reg[dr_val[69:68]] <= dr_val[63:32];
			dvb_val_reg[dr_val[69:68]] <= dr_val[31:0];
		end
	end

	// write match; halt lands a cycle late, so the stop is imprecise
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_dvb
			logic [31:0] mask;
			assign mask = dvb_size_reg[g] == `DVB_BYTE ? 32'h0000_00ff :
				dvb_size_reg[g] == `DVB_HALF ? 32'h0000_ffff : 32'hffff_ffff;
			assign dvb_hit[g] = dvb_en_reg[g] && cpu_wr_valid && cpu_wr_size == dvb_size_reg[g]
				&& cpu_wr_addr == dvb_addr_reg[g]
				&& (((cpu_wr_data & mask) == (dvb_val_reg[g] & mask)) != dvb_ne_reg[g]);
		end
	endgenerate
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			cpu_halt_req <= 1'b0;
		else
			cpu_halt_req <= |dvb_hit;
	end

	// trigger arming; event out mirrors watchpoint hits unless pins are gpio
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			armed_reg <= 1'b0;
			event_out_pin <= 1'b0;
		end else begin
			if (!cfg_reg[`CFG_TRACE_EN])
				armed_reg <= 1'b0;
			else if (wp_hit || (event_in_pin_s && !event_in_pin_d_reg))
				armed_reg <= 1'b1;
			event_out_pin <= cfg_reg[`CFG_GPIO] ? gpio_dout[7] : wp_hit;
		end
	end

	// with trace off, debug runs over the test pins alone
	trace_msg_tx u_trace (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.active(cfg_reg[`CFG_TRACE_EN] && (!cfg_reg[`CFG_WP_TRIG] || armed_reg)),
		.full_port(cfg_reg[`CFG_FULL_PORT]),
		.gpio_mode(cfg_reg[`CFG_GPIO]),
		.gpio_dout(gpio_dout[6:0]),
		.por_status(por_s),
		.br_valid(br_valid),
		.br_type(br_type),
		.br_addr(br_addr),
		.message_data_out(message_data_out),
		.message_start_end_out(message_start_end_out),
		.message_clock_out(message_clock_out)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	AST_TLR_IR: assert property (state_reg == jdap_pkg::TLR |=> ir_reg == `IR_IDCODE)
		else $error("ir not idcode after reset state");
	AST_COMPLIANCE: assert property (!tce_s |=> state_reg == jdap_pkg::TLR)
		else $error("port not held while compliance low");
	AST_CENSOR_HOLD: assert property (censor_lifted |=> censor_lifted)
		else $error("censorship came back without reset");
	AST_PW_MISMATCH: assert property (upd_dr && ir_reg == `IR_SEL_LOCK
		&& dr_val[63:0] != boot_password && !censor_lifted |=> !censor_lifted)
		else $error("censorship lifted on wrong password");
	AST_HIGHZ: assert property (ir_reg == `IR_HIGHZ ##1 ir_reg == `IR_HIGHZ |-> pad_oe == '0)
		else $error("pads driven under highz");
	AST_FUNC_PASS: assert property (!test_pins |=> pad_out == $past(core_pad_out))
		else $error("functional pad value disturbed");
	AST_TDO_IDLE: assert property (tck_fall && state_reg == jdap_pkg::RTI |=> !tdo_oe)
		else $error("tdo driven outside shift");
	AST_DVB_HALT: assert property (|dvb_hit |=> cpu_halt_req)
		else $error("breakpoint hit without halt");
	AST_TP_STEP: assert property (tp_step |-> $past(upd_dr) ##1 !tp_step)
		else $error("step pulse without update");
	COV_LIFT: cover property (!censor_lifted ##1 censor_lifted);
	COV_MEM: cover property (mem_req && mem_ack);
	COV_HALT: cover property (cpu_halt_req);
endmodule
`default_nettype wire

// *** jdap_consts.svh ***
`ifndef JDAP_CONSTS_SVH
`define JDAP_CONSTS_SVH

`define IR_W 5
`define IR_EXTEST 5'h00
`define IR_IDCODE 5'h01
`define IR_SAMPLE_PRELOAD 5'h02
`define IR_SAMPLE 5'h03
`define IR_HIGHZ 5'h09
`define IR_CLAMP 5'h0c
`define IR_SEL_TRACE 5'h10
`define IR_SEL_CORE 5'h11
`define IR_SEL_TIMEPROC 5'h12
`define IR_SEL_LOCK 5'h13
`define IR_BYPASS 5'h1f
`define IR_CAPTURE 5'h01
`define DR_SH_W 72
`define LEN_BYPASS 7'd1
`define LEN_IDCODE 7'd32
`define LEN_LOCK 7'd64
`define LEN_TRACE 7'd72
`define LEN_CORE 7'd70
`define LEN_TIMEPROC 7'd34
`define TRC_OP_CFG 2'h0
`define TRC_OP_READ 2'h1
`define TRC_OP_WRITE 2'h2
`define CFG_TRACE_EN 0
`define CFG_FULL_PORT 1
`define CFG_WP_TRIG 2
`define CFG_GPIO 3
`define CFG_RESET 6'h00
`define DVB_BYTE 2'h0
`define DVB_HALF 2'h1
`define DVB_WORD 2'h2
`define MESSAGE_START_END_OUT_IDLE 2'h3
`define MESSAGE_START_END_OUT_START 2'h0
`define MESSAGE_START_END_OUT_MID 2'h1
`define MESSAGE_START_END_OUT_END 2'h2
`define MSG_W 36
`define MDO_RESET 12'h001

`endif

// *** jdap_pkg.sv ***
package jdap_pkg;
	// gray steps along capture-shift-exit1 paths
	typedef enum logic [3:0] {
		TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
		SH_DR = 4'h6, EX1_DR = 4'h7, PAUSE_DR = 4'h5, EX2_DR = 4'h4,
		UPD_DR = 4'hc, SEL_IR = 4'hd, CAP_IR = 4'hf, SH_IR = 4'he,
		EX1_IR = 4'ha, PAUSE_IR = 4'hb, EX2_IR = 4'h9, UPD_IR = 4'h8
	} tap_state_t;
endpackage

// *** trace_msg_tx.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "jdap_consts.svh"
module trace_msg_tx (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic active,
	input wire logic full_port,
	input wire logic gpio_mode,
	input wire logic [6:0] gpio_dout,
	input wire logic por_status,
	input wire logic br_valid,
	input wire logic [1:0] br_type,
	input wire logic [31:0] br_addr,
	output logic [11:0] message_data_out,
	output logic [1:0] message_start_end_out,
	output logic message_clock_out
);
	logic [`MSG_W-1:0] pend_reg;
	logic pend_valid_reg;
	logic [`MSG_W-1:0] msg_reg;
	logic [3:0] beats_reg;
	logic beat_edge;
	logic [3:0] nbeats;

	assign beat_edge = message_clock_out;
	assign nbeats = full_port ? 4'd3 : 4'd9;

	// one waiting message; a third discontinuity during a busy message overwrites the waiting one
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_valid_reg <= 1'b0;
			pend_reg <= '0;
		end else if (br_valid && active) begin
			pend_valid_reg <= 1'b1;
			pend_reg <= {2'b00, br_type, br_addr};
		end else if (beat_edge && beats_reg == 4'd0) begin
			pend_valid_reg <= 1'b0;
		end
	end

	// data changes while the message clock falls, so the tool samples on its rise
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			message_data_out <= `MDO_RESET;
			message_start_end_out <= `MESSAGE_START_END_OUT_IDLE;
			message_clock_out <= 1'b0;
			msg_reg <= '0;
			beats_reg <= 4'd0;
		end else if (gpio_mode) begin
			message_data_out <= {8'h00, gpio_dout[3:0]};
			message_start_end_out <= gpio_dout[5:4];
			message_clock_out <= gpio_dout[6];
			beats_reg <= 4'd0;
		end else if (!active) begin
			message_data_out <= {11'h000, por_status};
			message_start_end_out <= `MESSAGE_START_END_OUT_IDLE;
			message_clock_out <= 1'b0;
			beats_reg <= 4'd0;
		end else begin
			message_clock_out <= ~message_clock_out;
			if (beat_edge) begin
				if (beats_reg != 4'd0) begin
					message_data_out <= full_port ? msg_reg[11:0] : {8'h00, msg_reg[3:0]};
					msg_reg <= full_port ? (msg_reg >> 12) : (msg_reg >> 4);
					beats_reg <= beats_reg - 4'd1;
					message_start_end_out <= (beats_reg == 4'd1) ? `MESSAGE_START_END_OUT_END : `MESSAGE_START_END_OUT_MID;
				end else if (pend_valid_reg) begin
					message_data_out <= full_port ? pend_reg[11:0] : {8'h00, pend_reg[3:0]};
					msg_reg <= full_port ? (pend_reg >> 12) : (pend_reg >> 4);
					beats_reg <= nbeats - 4'd1;
					message_start_end_out <= `MESSAGE_START_END_OUT_START;
				end else begin
					message_data_out <= 12'h000;
					message_start_end_out <= `MESSAGE_START_END_OUT_IDLE;
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	AST_POR_MDO: assert property (!gpio_mode && !active |=> message_data_out[0] == $past(por_status))
		else $error("por status missing on data bit zero");
	AST_MSG_LEN: assert property (active && !gpio_mode && beat_edge && beats_reg == 4'd0
		&& pend_valid_reg && !full_port ##1 (active && !gpio_mode && !full_port)[*8]
		|-> message_start_end_out == `MESSAGE_START_END_OUT_MID)
		else $error("reduced message ended early");
	COV_REDUCED: cover property (message_start_end_out == `MESSAGE_START_END_OUT_END && !full_port);
	COV_FULL: cover property (message_start_end_out == `MESSAGE_START_END_OUT_END && full_port);
endmodule
`default_nettype wire

// *** jtag_tool_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// behavioural boundary-scan tool: tck rests low between frames
module jtag_tool_model (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// tms starts high so a stray clock before the first frame walks toward test-logic-reset
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one tck period of 200 ns; tdo read late in the high phase because the
	// device answers several system clocks after the fall
	task automatic bit_io(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#100 tck = 1'b1;
		#95 o = tdo;
		#5 tck = 1'b0;
		tdi = ~d; // no stale bit left on the line
	endtask
	// five clocks with tms high reach test-logic-reset from any state
	task automatic tap_reset();
		logic o;
		repeat (5) bit_io(1'b1, 1'b0, o);
		bit_io(1'b0, 1'b0, o);
	endtask
	// from idle: select, capture, shift n bits lsb first, update, idle
	task automatic scan(input bit ir, input int n, input logic [71:0] din,
			output logic [71:0] dout);
		logic o;
		dout = '0;
		bit_io(1'b1, 1'b0, o);
		if (ir) bit_io(1'b1, 1'b0, o);
		bit_io(1'b0, 1'b0, o);
		bit_io(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			bit_io(i == n - 1, din[i], o);
			dout[i] = o;
		end
		bit_io(1'b1, 1'b0, o);
		bit_io(1'b0, 1'b0, o);
	endtask
endmodule
`default_nettype wire

// *** jtag_debug_access_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "jdap_consts.svh"
module jtag_debug_access_port_tb;
	localparam logic [31:0] ID_VAL = 32'h0abc_5001; // arbitrary value
	localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
	logic sys_clk, rst_b, tck, tms, tdi, tdo_out, tdo_oe, tdo_line, censor_lifted;
	logic tap_compliance_enable, br_valid, wp_hit, event_in_pin, por_status, cpu_wr_valid;
	logic [15:0] pad_out, pad_oe, core_pad_out, core_pad_oe;
	logic [1:0] br_type, cpu_wr_size, message_start_end_out;
	logic [31:0] br_addr, cpu_wr_addr, cpu_wr_data, mem_addr, mem_wdata, tp_brk_addr;
	logic [11:0] message_data_out;
	logic cpu_halt_req, mem_req, mem_we, mem_ack, tp_brk_en, tp_step, message_clock_out;
	logic event_out_pin;
	logic [7:0] gpio_dout;
	logic [31:0] mem_rdata;
	logic [71:0] d;
	int n_fail = 0, checks_done = 0, n_halt = 0, n_step = 0, k;
	jtag_debug_access_port #(.PAD_N(16), .IDCODE_VALUE(ID_VAL)) u_dut (.sys_clk(sys_clk),
		.rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
		.tap_compliance_enable(tap_compliance_enable), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
		.pad_in(16'h3c3c), .core_pad_out(core_pad_out), .core_pad_oe(core_pad_oe),
		.pad_out(pad_out), .pad_oe(pad_oe), .boot_password(PW), .censor_lifted(censor_lifted),
		.br_valid(br_valid), .br_type(br_type), .br_addr(br_addr), .wp_hit(wp_hit),
		.event_in_pin(event_in_pin), .por_status(por_status), .gpio_dout(gpio_dout),
		.message_data_out(message_data_out), .message_start_end_out(message_start_end_out),
		.message_clock_out(message_clock_out), .event_out_pin(event_out_pin),
		.cpu_wr_valid(cpu_wr_valid),
		.cpu_wr_addr(cpu_wr_addr), .cpu_wr_data(cpu_wr_data), .cpu_wr_size(cpu_wr_size),
		.cpu_halt_req(cpu_halt_req), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.tp_brk_en(tp_brk_en), .tp_brk_addr(tp_brk_addr), .tp_step(tp_step));
	// released tdo line is pulled up
	assign tdo_line = tdo_oe ? tdo_out : 1'b1;
	jtag_tool_model u_tool (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
	// 40 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// pulses are counted so a missed or doubled one shows
	always @(posedge sys_clk) begin
		n_halt <= n_halt + (cpu_halt_req === 1'b1);
		n_step <= n_step + (tp_step === 1'b1);
	end
	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic lost(input int lim);
		if (k >= lim) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic t_idle();
		check(message_data_out, 12'h001);
		check(message_start_end_out, `MESSAGE_START_END_OUT_IDLE);
		check(pad_out, core_pad_out);
		por_status = 1'b0;
		settle(4);
		check(message_data_out, 12'h000);
	endtask
	task automatic t_ids();
		u_tool.tap_reset();
		u_tool.scan(1'b0, 32, 72'h0, d);
		check(d[31:0], ID_VAL);
		u_tool.scan(1'b1, 5, `IR_BYPASS, d);
		check(d[4:0], `IR_CAPTURE);
		u_tool.scan(1'b0, 8, 72'ha5, d);
		check(d[7:0], 8'h4a);
		u_tool.scan(1'b1, 5, `IR_HIGHZ, d);
		settle(4);
		check(pad_oe, 16'h0000);
	endtask
	// preload through the boundary register, then drive it out and clamp it
	task automatic t_bsr();
		u_tool.scan(1'b1, 5, `IR_SAMPLE_PRELOAD, d);
		u_tool.scan(1'b0, 16, 72'h1234, d);
		check(d[15:0], 16'h3c3c);
		u_tool.scan(1'b1, 5, `IR_EXTEST, d);
		settle(2);
		check({pad_oe, pad_out}, {16'hffff, 16'h1234});
		core_pad_oe = 16'h0f0f;
		u_tool.scan(1'b1, 5, `IR_CLAMP, d);
		settle(2);
		check({pad_oe, pad_out}, {16'hffff, 16'h1234});
		u_tool.scan(1'b1, 5, `IR_SAMPLE, d);
		settle(2);
		check({pad_oe, pad_out}, {core_pad_oe, core_pad_out});
	endtask
	// compliance low refuses shifts and drops back to the identification instruction
	task automatic t_comp();
		u_tool.scan(1'b1, 5, `IR_HIGHZ, d);
		tap_compliance_enable = 1'b0;
		settle(4);
		u_tool.scan(1'b1, 5, `IR_BYPASS, d);
		check(d[4:0], 5'h1f);
		check(pad_oe, core_pad_oe);
		tap_compliance_enable = 1'b1;
		settle(4);
		u_tool.tap_reset();
		u_tool.scan(1'b0, 32, 72'h0, d);
		check(d[31:0], ID_VAL);
	endtask
	task automatic t_lock();
		u_tool.scan(1'b1, 5, `IR_SEL_LOCK, d);
		u_tool.scan(1'b0, 64, {8'h00, ~PW}, d);
		check(d[63:0], 64'h0);
		settle(4);
		check(censor_lifted, 1'b0);
		u_tool.scan(1'b0, 64, {8'h00, PW}, d);
		settle(4);
		check(censor_lifted, 1'b1);
		u_tool.tap_reset();
		check(censor_lifted, 1'b1);
	endtask
	task automatic t_timeproc();
		u_tool.scan(1'b1, 5, `IR_SEL_TIMEPROC, d);
		u_tool.scan(1'b0, 34, {38'h0, 2'h1, 32'h0000_1230}, d);
		settle(4);
		check({tp_brk_en, tp_brk_addr}, {1'b1, 32'h0000_1230});
		u_tool.scan(1'b0, 34, {38'h0, 2'h3, 32'h0000_1230}, d);
		check(n_step, 1);
	endtask
	task automatic t_core_bp();
		u_tool.scan(1'b1, 5, `IR_SEL_CORE, d);
		u_tool.scan(1'b0, 70, {2'h0, 2'h0, 2'h2, `DVB_WORD, 32'h0000_0040, 32'hcafe_f00d}, d);
		cpu_wr_addr = 32'h0000_0040;
		cpu_wr_size = `DVB_WORD;
		cpu_wr_data = 32'hcafe_f00c; // one bit off: must not halt
		cpu_wr_valid = 1'b1;
		settle(1);
		cpu_wr_data = 32'hcafe_f00d;
		settle(1);
		cpu_wr_valid = 1'b0;
		settle(4);
		check(n_halt, 1);
	endtask
	task automatic t_mem();
		u_tool.scan(1'b1, 5, `IR_SEL_TRACE, d);
		u_tool.scan(1'b0, 72, {`TRC_OP_WRITE, 32'h0000_0100, 32'h1111_2222, 6'h00}, d);
		for (k = 0; k < 50 && mem_req !== 1'b1; k++) settle(1);
		lost(50);
		check({mem_we, mem_addr, mem_wdata}, {1'b1, 32'h0000_0100, 32'h1111_2222});
		mem_ack = 1'b1;
		settle(1);
		mem_ack = 1'b0;
		settle(2);
		check(mem_req, 1'b0);
		u_tool.scan(1'b0, 72, {`TRC_OP_READ, 32'h0000_0200, 32'h0, 6'h00}, d);
		for (k = 0; k < 50 && mem_req !== 1'b1; k++) settle(1);
		lost(50);
		check({mem_we, mem_addr}, {1'b0, 32'h0000_0200});
		mem_rdata = 32'h5a5a_0f0f;
		mem_ack = 1'b1;
		settle(1);
		mem_ack = 1'b0;
		mem_rdata = 32'h0000_0000;
		// read data comes back at the next trace capture
		u_tool.scan(1'b0, 72, {`TRC_OP_CFG, 64'h0, 6'h00}, d);
		check(d[69:6], {32'h0000_0200, 32'h5a5a_0f0f});
	endtask
	task automatic t_trace();
		logic [35:0] msg;
		// reduced port first, then full port
		for (int f = 0; f < 2; f++) begin
			u_tool.scan(1'b0, 72, {`TRC_OP_CFG, 64'h0, 4'h0, f[0], 1'b1}, d);
			br_type = f ? 2'h2 : 2'h1;
			br_addr = f ? 32'h1234_5678 : 32'h8000_0010;
			br_valid = 1'b1;
			settle(1);
			br_valid = 1'b0;
			for (k = 0; k < 20 && message_start_end_out !== `MESSAGE_START_END_OUT_START; k++) settle(1);
			lost(20);
			msg = '0;
			// each beat stands two cycles; take it, then step to the next
			for (int b = 0; b < (f ? 3 : 9); b++) begin
				if (b > 0) settle(2);
				msg = f ? {message_data_out, msg[35:12]} : {message_data_out[3:0], msg[35:4]};
			end
			check(message_start_end_out, `MESSAGE_START_END_OUT_END);
			check(msg, {2'b00, br_type, br_addr});
		end
	endtask
	// trace waits for the watchpoint; then the pins turn into plain outputs
	task automatic t_wp();
		u_tool.scan(1'b0, 72, {`TRC_OP_CFG, 64'h0, 6'h05}, d);
		br_valid = 1'b1;
		settle(1);
		br_valid = 1'b0;
		settle(6);
		check(message_start_end_out, `MESSAGE_START_END_OUT_IDLE);
		wp_hit = 1'b1;
		settle(1);
		wp_hit = 1'b0;
		check(event_out_pin, 1'b1);
		br_valid = 1'b1;
		settle(1);
		br_valid = 1'b0;
		for (k = 0; k < 20 && message_start_end_out !== `MESSAGE_START_END_OUT_START; k++) settle(1);
		lost(20);
		gpio_dout = 8'h9a;
		u_tool.scan(1'b0, 72, {`TRC_OP_CFG, 64'h0, 6'h08}, d);
		settle(2);
		check({event_out_pin, message_start_end_out, message_data_out}, {1'b1, 2'h1, 12'h00a});
		check(message_clock_out, 1'b0);
	endtask
	// all stimulus changes on falling edges of the system clock
	initial begin
		{rst_b, br_valid, wp_hit, event_in_pin, cpu_wr_valid, mem_ack} = 6'h00;
		{br_type, cpu_wr_size, br_addr, cpu_wr_addr, cpu_wr_data, mem_rdata, gpio_dout} = '0;
		por_status = 1'b1;
		tap_compliance_enable = 1'b1;
		core_pad_out = 16'ha5a5;
		core_pad_oe = 16'hffff;
		settle(4);
		rst_b = 1'b1;
		settle(4);
		t_idle();
		t_ids();
		t_bsr();
		t_comp();
		t_lock();
		t_timeproc();
		t_core_bp();
		t_mem();
		t_trace();
		t_wp();
		stop_test();
	end
endmodule
`default_nettype wire
